// >>> hw/io_space_decode.sv
// Top of the I/O space decoder: short, bit and data-space accesses
module io_space_decode
  import io_space_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  // Configuration
  input wire logic LEGACY_MODE,
  input wire logic [7:0] W1C_MASK,
  input wire logic [7:0] HW_FLAGS,
  // Request from core
  input wire logic REQ_VALID,
  input wire io_op_t REQ_OP,
  input wire logic [15:0] REQ_ADDR,
  input wire logic REQ_WRITE,
  input wire logic [2:0] REQ_BIT,
  input wire logic [7:0] REQ_WDATA,
  // Answer to core
  output logic RSP_VALID,
  output logic [7:0] RSP_RDATA,
  output logic RSP_SKIP,
  output logic RSP_ERR,
  // Working register and SRAM forwarding
  output logic WORK_SEL,
  output logic SRAM_SEL,
  output logic [15:0] FWD_ADDR
);
  io_store_if st();

  // Map constants must tile the data space with no gap or overlap
  if (int'(IO_OFFSET) != NUM_WORK_REGS) begin : g_work_chk
    $error("io_space_decode: working registers do not end at the I/O offset");
  end
  if (int'(SHORT_IO_HI) + 1 != IO_LOCS) begin : g_short_chk
    $error("io_space_decode: short window size mismatch");
  end
  if (int'(EXT_IO_LO) != int'(IO_OFFSET) + IO_LOCS) begin : g_ext_lo_chk
    $error("io_space_decode: extended region does not follow the short window");
  end
  if (int'(EXT_IO_HI) - int'(EXT_IO_LO) + 1 != EXT_LOCS) begin : g_ext_n_chk
    $error("io_space_decode: extended region size mismatch");
  end
  if (BIT_IO_HI >= SHORT_IO_HI) begin : g_bit_chk
    $error("io_space_decode: bit window must sit inside the short window");
  end
  if (NUM_WORK_REGS + IO_LOCS + EXT_LOCS != int'(EXT_IO_HI) + 1) begin : g_map_chk
    $error("io_space_decode: data space map does not close at the extended top");
  end

  io_reg_store #(.IO_N(IO_LOCS), .EXT_N(EXT_LOCS)) u_store (
    .clk(CLK_SYS),
    .nrst(NRST),
    .ce(CE),
    .w1c_mask(W1C_MASK),
    .hw_flags(HW_FLAGS),
    .bus(st)
  );

  function automatic io_tgt_t ds_target(input logic [15:0] a, input logic legacy);
    if (a < IO_OFFSET) return TGT_WORK;
    if (a < EXT_IO_LO) return TGT_IO;
    if (a <= EXT_IO_HI) return legacy ? TGT_SRAM : TGT_EXT;
    return TGT_SRAM;
  endfunction

  function automatic logic [7:0] ds_index(input logic [15:0] a);
    // Store index equals data-space address less the offset
    logic [15:0] d;
    d = a - IO_OFFSET;
    return d[7:0];
  endfunction

  function automatic logic short_ok(input logic [15:0] a);
    return a <= 16'(SHORT_IO_HI);
  endfunction

  function automatic logic bit_ok(input logic [15:0] a);
    return a <= 16'(BIT_IO_HI);
  endfunction

  function automatic logic skip_hit(input io_op_t op, input logic b);
    case (op)
      OP_SKIP_SET: return b;
      OP_SKIP_CLEAR: return !b;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic store_write(input io_op_t op, input logic w);
    case (op)
      OP_IO_WRITE: return 1'b1;
      OP_BIT_SET, OP_BIT_CLEAR: return 1'b1;
      OP_DS_ACCESS: return w;
      default: return 1'b0;
    endcase
  endfunction

  // Bit ops rebuild the whole byte from what was read
  function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] b, input logic val);
    logic [7:0] v;
    v = old;
    v[b] = val;
    return v;
  endfunction

  io_tgt_t tgt;
  logic [15:0] ds_addr;
  logic ok;
  logic is_bit_op;
  logic bit_now;
  logic [7:0] rmw;

  logic rsp_valid_r, rsp_valid_nxt;
  logic [7:0] rsp_rdata_r, rsp_rdata_nxt;
  logic rsp_skip_r, rsp_skip_nxt;
  logic rsp_err_r, rsp_err_nxt;
  logic work_sel_r, work_sel_nxt;
  logic sram_sel_r, sram_sel_nxt;
  logic [15:0] fwd_addr_r, fwd_addr_nxt;

  always_comb begin
    ok = 1'b0;
    is_bit_op = 1'b0;
    // Short forms carry a 6-bit I/O address
    ds_addr = {10'h000, REQ_ADDR[5:0]} + IO_OFFSET;
    case (REQ_OP)
      OP_IO_READ, OP_IO_WRITE: ok = short_ok(REQ_ADDR);
      OP_BIT_SET, OP_BIT_CLEAR, OP_SKIP_SET, OP_SKIP_CLEAR: begin
        is_bit_op = 1'b1;
        ok = bit_ok(REQ_ADDR);
      end
      OP_DS_ACCESS: begin
        ds_addr = REQ_ADDR;
        ok = 1'b1;
      end
      default: ok = 1'b0;
    endcase
    tgt = ds_target(ds_addr, LEGACY_MODE);
    st.index = ds_index(ds_addr);
    st.ext_sel = tgt == TGT_EXT;
    bit_now = st.rdata[REQ_BIT];
    // Whole byte written back, so set flags read as one get cleared
    rmw = bit_merge(st.rdata, REQ_BIT, REQ_OP == OP_BIT_SET);
    st.wdata = is_bit_op ? rmw : REQ_WDATA;
    // Refused ops and forwarded targets never touch the store
    st.wr_en = REQ_VALID && ok && (tgt == TGT_IO || tgt == TGT_EXT) && store_write(REQ_OP, REQ_WRITE);
  end

  // Answer is registered on the same enabled edge that takes the request
  always_comb begin
    rsp_valid_nxt = REQ_VALID;
    rsp_rdata_nxt = rsp_rdata_r;
    rsp_skip_nxt = 1'b0;
    rsp_err_nxt = 1'b0;
    work_sel_nxt = 1'b0;
    sram_sel_nxt = 1'b0;
    fwd_addr_nxt = fwd_addr_r;
    if (REQ_VALID) begin
      if (!ok) begin
        // Refused ops leave the store untouched but answer an error with zero data
        rsp_err_nxt = 1'b1;
        rsp_rdata_nxt = ZERO_BYTE;
      end else begin
        case (tgt)
          TGT_IO, TGT_EXT: rsp_rdata_nxt = st.rdata;
          TGT_WORK: begin
            work_sel_nxt = 1'b1;
            fwd_addr_nxt = ds_addr;
            rsp_rdata_nxt = ZERO_BYTE;
          end
          TGT_SRAM: begin
            sram_sel_nxt = 1'b1;
            fwd_addr_nxt = ds_addr;
            rsp_rdata_nxt = ZERO_BYTE;
          end
          default: rsp_rdata_nxt = ZERO_BYTE;
        endcase
        rsp_skip_nxt = skip_hit(REQ_OP, bit_now);
      end
    end
  end

  // CE low freezes the answer together with the store
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= ZERO_BYTE;
      rsp_skip_r <= 1'b0;
      rsp_err_r <= 1'b0;
      work_sel_r <= 1'b0;
      sram_sel_r <= 1'b0;
      fwd_addr_r <= 16'h0000;
    end else if (CE) begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_rdata_r <= rsp_rdata_nxt;
      rsp_skip_r <= rsp_skip_nxt;
      rsp_err_r <= rsp_err_nxt;
      work_sel_r <= work_sel_nxt;
      sram_sel_r <= sram_sel_nxt;
      fwd_addr_r <= fwd_addr_nxt;
    end
  end

  assign RSP_VALID = rsp_valid_r;
  assign RSP_RDATA = rsp_rdata_r;
  assign RSP_SKIP = rsp_skip_r;
  assign RSP_ERR = rsp_err_r;
  assign WORK_SEL = work_sel_r;
  assign SRAM_SEL = sram_sel_r;
  assign FWD_ADDR = fwd_addr_r;
endmodule

// >>> hw/io_space_pkg.sv
// Package holding address map and op codes of the I/O space decoder
package io_space_pkg;
  localparam logic [15:0] IO_OFFSET = 16'h0020;
  localparam logic [15:0] EXT_IO_LO = 16'h0060;
  localparam logic [15:0] EXT_IO_HI = 16'h00FF;
  localparam logic [5:0] BIT_IO_HI = 6'h1F;
  localparam logic [5:0] SHORT_IO_HI = 6'h3F;
  localparam int NUM_WORK_REGS = 32;
  localparam int IO_LOCS = 64;
  localparam int EXT_LOCS = 160;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] DEF_W1C_MASK = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_IO_READ = 3'b001,
    OP_IO_WRITE = 3'b010,
    OP_BIT_SET = 3'b011,
    OP_BIT_CLEAR = 3'b100,
    OP_SKIP_SET = 3'b101,
    OP_SKIP_CLEAR = 3'b110,
    OP_DS_ACCESS = 3'b111
  } io_op_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_WORK = 3'b001,
    TGT_IO = 3'b010,
    TGT_EXT = 3'b011,
    TGT_SRAM = 3'b100
  } io_tgt_t;
endpackage

// >>> hw/io_store_if.sv
// Interface carrying decoded accesses from the decoder to the register store
interface io_store_if;
  import io_space_pkg::*;
  logic wr_en;
  logic [7:0] index;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ext_sel;
  modport decoder (output wr_en, output index, output wdata, output ext_sel, input rdata);
  modport store (input wr_en, input index, input wdata, input ext_sel, output rdata);
endinterface

// >>> hw/io_reg_store.sv
// Register store: 64 short I/O locations plus the extended region
module io_reg_store
  import io_space_pkg::*;
#(
  parameter int IO_N = IO_LOCS,
  parameter int EXT_N = EXT_LOCS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] w1c_mask,
  input wire logic [7:0] hw_flags,
  io_store_if.store bus
);
  // Decoder index map is fixed, so only the package sizes are served
  if (IO_N != IO_LOCS || EXT_N != EXT_LOCS) begin : g_size_chk
    $error("io_reg_store: unsupported size");
  end

  logic [7:0] mem_r [IO_N+EXT_N];
  logic [7:0] mem_nxt [IO_N+EXT_N];

  assign bus.rdata = (int'(bus.index) < IO_N + EXT_N) ? mem_r[bus.index] : ZERO_BYTE;

  always_comb begin
    for (int i = 0; i < IO_N + EXT_N; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    // Hardware flags on location 0; set beats a same-cycle clear
    mem_nxt[0] = mem_r[0] | (hw_flags & w1c_mask);
    // Extended slots only take writes the decoder marked as extended
    if (bus.wr_en && (bus.ext_sel || int'(bus.index) < IO_N)) begin
      if (bus.index == 8'h00) begin
        // Ones clear flags, zeros leave them, other bits store
        mem_nxt[0] = ((bus.wdata & ~w1c_mask) | (mem_r[0] & w1c_mask & ~bus.wdata)) | (hw_flags & w1c_mask);
      end else begin
        mem_nxt[bus.index] = bus.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < IO_N + EXT_N; i++) begin
        mem_r[i] <= ZERO_BYTE;
      end
    end else if (ce) begin
      mem_r <= mem_nxt;
    end
  end
endmodule

// >>> tb/io_space_decode_sva.sv
// Port checker for the I/O space decoder
module io_space_decode_sva
  import io_space_pkg::*;
(
  // Watched ports
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  input wire logic LEGACY_MODE,
  input wire logic REQ_VALID,
  input wire io_op_t REQ_OP,
  input wire logic [15:0] REQ_ADDR,
  input wire logic RSP_VALID,
  input wire logic RSP_ERR,
  input wire logic WORK_SEL,
  input wire logic SRAM_SEL,
  input wire logic [15:0] FWD_ADDR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  wire logic tk = CE && REQ_VALID;
  wire logic ds = tk && REQ_OP == OP_DS_ACCESS;
  wire logic bo = tk && REQ_OP inside {OP_BIT_SET, OP_BIT_CLEAR, OP_SKIP_SET, OP_SKIP_CLEAR};
  rsp_answer_a: assert property (tk |=> RSP_VALID) else $error("no answer");
  rsp_quiet_a: assert property (CE && !REQ_VALID |=> !RSP_VALID) else $error("stray answer");
  bit_refuse_a: assert property (bo && REQ_ADDR > 16'h001F |=> RSP_ERR) else $error("bit op not refused");
  skip_low_a: assert property (bo && REQ_ADDR <= 16'h001F |=> !RSP_ERR) else $error("low bit op refused");
  short_range_a: assert property (tk && REQ_OP inside {OP_IO_READ, OP_IO_WRITE}
    |=> RSP_ERR == ($past(REQ_ADDR) > 16'h003F)) else $error("short range");
  work_fwd_a: assert property (ds && REQ_ADDR < 16'h0020
    |=> WORK_SEL && FWD_ADDR == $past(REQ_ADDR)) else $error("work forward");
  io_map_a: assert property (ds && REQ_ADDR inside {[16'h0020:16'h005F]}
    |=> !(WORK_SEL || SRAM_SEL || RSP_ERR)) else $error("io map");
  ext_map_a: assert property (ds && REQ_ADDR inside {[16'h0060:16'h00FF]}
    |=> SRAM_SEL == $past(LEGACY_MODE) && !RSP_ERR) else $error("ext map");
  cover property (bo);
  cover property (ds && LEGACY_MODE);
  cover property (WORK_SEL);
endmodule

// >>> tb/core_model.sv
// Behavioural core issuing one request at a time
module core_model
  import io_space_pkg::*;
(
  // Request side
  input wire logic clk,
  output logic req_valid,
  output io_op_t req_op,
  output logic [15:0] req_addr,
  output logic req_write,
  output logic [2:0] req_bit,
  output logic [7:0] req_wdata,
  // Answer side
  input wire logic rsp_valid,
  output logic got
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_op = OP_NONE;
    {req_valid, req_addr, req_write, req_bit, req_wdata, got} = '0;
  end
  // Answer is registered on the taking edge and sampled at the next negedge, half a cycle later
  task automatic req(input io_op_t op, input logic [15:0] a, input logic w, input logic [2:0] b, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    // Writes aim only at mapped locations
    req_write = w;
    req_bit = b;
    // Callers keep unused data bits zero
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    // Released address and data lines flip so stale values never pass
    req_addr = ~a;
    req_wdata = ~d;
    got = rsp_valid;
  endtask
endmodule

// >>> tb/io_space_decode_tb.sv
// Self-checking bench for the I/O space decoder
module io_space_decode_tb
  import io_space_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, ce, legacy, got, req_valid, req_write, rsp_valid, rsp_skip, rsp_err, work_sel, sram_sel;
  logic [7:0] w1c, hw_flags, req_wdata, rsp_rdata;
  logic [15:0] req_addr, fwd_addr;
  logic [2:0] req_bit;
  io_op_t req_op;
  int fail_count, compares;
  always #50 clk = ~clk;
  io_space_decode dut (.CLK_SYS(clk), .NRST(nrst), .CE(ce), .LEGACY_MODE(legacy), .W1C_MASK(w1c),
    .HW_FLAGS(hw_flags), .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WRITE(req_write),
    .REQ_BIT(req_bit), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_SKIP(rsp_skip),
    .RSP_ERR(rsp_err), .WORK_SEL(work_sel), .SRAM_SEL(sram_sel), .FWD_ADDR(fwd_addr));
  core_model core (.*);
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic go(input io_op_t op, input logic [15:0] a, input logic w, input logic [2:0] b, input logic [7:0] d);
    core.req(op, a, w, b, d);
    check(16'(got), 16'h0001);
  endtask
  task automatic t_short;
    check(16'(rsp_valid), 16'h0000);
    go(OP_IO_WRITE, 16'h0003, 1'b0, 3'd0, 8'hA5);
    go(OP_DS_ACCESS, 16'h0023, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h00A5);
    go(OP_DS_ACCESS, 16'h005F, 1'b1, 3'd0, 8'h3C);
    go(OP_IO_READ, 16'h003F, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h003C);
    go(OP_IO_READ, 16'h0040, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_err), 16'h0001);
    go(OP_NONE, 16'h0003, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_err), 16'h0001);
  endtask
  task automatic t_bits;
    go(OP_BIT_SET, 16'h0005, 1'b0, 3'd2, 8'h00);
    go(OP_BIT_SET, 16'h0005, 1'b0, 3'd7, 8'h00);
    check(16'(rsp_rdata), 16'h0004);
    go(OP_BIT_CLEAR, 16'h0005, 1'b0, 3'd2, 8'h00);
    check(16'(rsp_rdata), 16'h0084);
    go(OP_SKIP_SET, 16'h0005, 1'b0, 3'd7, 8'h00);
    check(16'(rsp_skip), 16'h0001);
    go(OP_SKIP_CLEAR, 16'h0005, 1'b0, 3'd7, 8'h00);
    check(16'(rsp_skip), 16'h0000);
    go(OP_SKIP_CLEAR, 16'h0005, 1'b0, 3'd2, 8'h00);
    check(16'(rsp_skip), 16'h0001);
    go(OP_BIT_SET, 16'h0020, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_err), 16'h0001);
    go(OP_IO_READ, 16'h0020, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h0000);
  endtask
  task automatic t_flags;
    hw_flags = 8'h03;
    @(negedge clk);
    hw_flags = 8'h00;
    go(OP_IO_WRITE, 16'h0000, 1'b0, 3'd0, 8'h01);
    go(OP_IO_READ, 16'h0000, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h0002);
    go(OP_BIT_SET, 16'h0000, 1'b0, 3'd7, 8'h00);
    go(OP_IO_READ, 16'h0000, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h0080);
    // Flag set in the same cycle as its clear must survive
    hw_flags = 8'h01;
    go(OP_IO_WRITE, 16'h0000, 1'b0, 3'd0, 8'h01);
    hw_flags = 8'h00;
    check(16'(rsp_rdata), 16'h0081);
    go(OP_IO_READ, 16'h0000, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h0001);
  endtask
  task automatic t_map;
    go(OP_DS_ACCESS, 16'h0010, 1'b0, 3'd0, 8'h00);
    check(16'(work_sel), 16'h0001);
    check(fwd_addr, 16'h0010);
    go(OP_DS_ACCESS, 16'h0060, 1'b1, 3'd0, 8'h5A);
    go(OP_DS_ACCESS, 16'h0060, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h005A);
    check(16'(sram_sel), 16'h0000);
    legacy = 1'b1;
    go(OP_DS_ACCESS, 16'h00FF, 1'b0, 3'd0, 8'h00);
    check(16'(sram_sel), 16'h0001);
    check(fwd_addr, 16'h00FF);
    go(OP_DS_ACCESS, 16'h0060, 1'b1, 3'd0, 8'h11);
    check(16'(sram_sel), 16'h0001);
    legacy = 1'b0;
    go(OP_DS_ACCESS, 16'h0060, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h005A);
  endtask
  task automatic t_ce;
    // One idle enabled edge first, so the last answer has dropped
    @(negedge clk);
    ce = 1'b0;
    core.req(OP_IO_WRITE, 16'h0007, 1'b0, 3'd0, 8'hC3);
    check(16'(got), 16'h0000);
    ce = 1'b1;
    go(OP_IO_READ, 16'h0007, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h0000);
  endtask
  task automatic t_reset;
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    check(16'(rsp_valid), 16'h0000);
    go(OP_IO_READ, 16'h0003, 1'b0, 3'd0, 8'h00);
    check(16'(rsp_rdata), 16'h0000);
  endtask
  task automatic results;
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {clk, nrst, legacy, hw_flags} = '0;
    ce = 1'b1;
    w1c = 8'h03;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_short();
    t_bits();
    t_flags();
    t_map();
    t_ce();
    t_reset();
    results();
  end
endmodule
bind io_space_decode io_space_decode_sva chk (.*);
